//--- core/epfl_dfc.sv
// Digital-to-frequency unit: accumulates power and emits fixed-width pulses.
// Assumes power and threshold are stable between oscillator ticks.
`timescale 1ns/1ps
module epfl_dfc
    import epfl_pkg::*;
#(
    parameter int unsigned WIDTH_TICKS = 18,
    parameter int unsigned CNT_W       = 16
) (
    input wire logic sys_clk,
    input wire logic srst,
    epfl_dfc_if.unit port
);

    logic [ACC_W-1:0] acc_q;
    logic [ACC_W-1:0] acc_d;
    logic [ACC_W-1:0] sum_w;
    logic             cross_w;
    logic [CNT_W-1:0] wid_q;
    logic [CNT_W-1:0] wid_d;
    logic             pulse_q;

    // ************************************************************
    // Accumulate and cross
    // ************************************************************
    // Residue is kept after subtracting, so no energy is lost
    assign sum_w   = acc_q + port.power;
    assign cross_w = port.tick && (sum_w >= port.threshold);
    assign acc_d   = !port.tick ? acc_q :
                     cross_w    ? sum_w - port.threshold : sum_w;

    // Width counter runs on oscillator ticks; a crossing restarts it
    assign wid_d = cross_w ? WIDTH_TICKS[CNT_W-1:0] :
                   (port.tick && wid_q != '0) ? wid_q - 1'b1 : wid_q;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            acc_q   <= '0;
            wid_q   <= '0;
            pulse_q <= 1'b0;
        end else begin
            acc_q   <= acc_d;
            wid_q   <= wid_d;
            pulse_q <= (wid_d != '0);
        end
    end

    assign port.pulse = pulse_q;

endmodule

//--- core/epfl_energy_pulse.sv
// Energy pulse generation and phase/neutral fault supervision.
// Assumes current and voltage samples arrive on sys_clk; select pins are asynchronous.
`timescale 1ns/1ps
module epfl_energy_pulse
    import epfl_pkg::*;
#(
    parameter int unsigned OSC_FREQ_HZ         = OSC_HZ,
    parameter longint unsigned ENERGY_Q        = ENERGY_QUANTUM,
    parameter int unsigned F_PULSE_W           = F_PULSE_TICKS,
    parameter int unsigned FAULT_POWERUP_TICKS = FAULT_POWERUP_MS * (OSC_HZ / MS_PER_S),
    parameter int unsigned FAULT_SETTLE_TICKS  = FAULT_SETTLE_MS * (OSC_HZ / MS_PER_S)
) (
    input  wire logic                       sys_clk,
    input  wire logic                       srst,
    input  wire logic signed [epfl_pkg::SAMPLE_W-1:0] voltage_sample,
    input  wire logic signed [epfl_pkg::SAMPLE_W-1:0] phase_current_input,
    input  wire logic signed [epfl_pkg::SAMPLE_W-1:0] neutral_current_input,
    input  wire logic                       rate_select_high,
    input  wire logic                       rate_select_low,
    input  wire logic                       cal_scale_select,
    input  wire logic                       gain_select,
    output logic                            energy_pulse_out_a,
    output logic                            energy_pulse_out_b,
    output logic                            calibration_pulse_out,
    output logic                            fault_flag,
    output logic                            neutral_active
);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [3:0]               pin_meta_q;
    logic [3:0]               pin_sync_q;
    logic [1:0]               rate_sel_w;
    logic                     scale_w;
    logic                     gain_w;

    logic [TICK_W-1:0]        phase_q;
    logic [TICK_W-1:0]        phase_d;
    logic [TICK_W-1:0]        phase_sum_w;
    logic                     osc_tick_w;

    logic signed [SAMPLE_W-1:0] cur_sel_w;
    logic signed [GAIN_W-1:0]   cur_gain_w;
    logic signed [PROD_W-1:0]   prod_w;
    logic signed [PROD_W+LPF_SHIFT-1:0] lpf_q;
    logic signed [PROD_W+LPF_SHIFT-1:0] lpf_d;
    logic signed [PROD_W-1:0]   lpf_out_w;
    logic [ACC_W-1:0]         power_w;

    logic [4:0]               base_exp_w;
    logic [4:0]               cf_exp_w;
    logic [ACC_W-1:0]         f_thr_w;
    logic [ACC_W-1:0]         cf_thr_w;

    logic signed [SAMPLE_W-1:0] cur_in_w [2];
    logic [MAG_W-1:0]         mag_w [2];
    logic [MAG_W+CUR_AVG_SHIFT-1:0] avg_q [2];
    logic [MAG_W-1:0]         avg_w [2];

    logic [MAG_W-1:0]         act_w;
    logic [MAG_W-1:0]         ina_w;
    logic                     quiet_w;
    logic                     differ_w;
    logic                     swap_w;
    epfl_fault_state_t        state_q;
    epfl_fault_state_t        state_d;
    epfl_fault_state_t        want_w;
    logic [FAULT_CNT_W-1:0]   fcnt_q;
    logic [FAULT_CNT_W-1:0]   fcnt_d;
    logic [FAULT_CNT_W-1:0]   limit_w;
    logic                     powerup_q;
    logic                     powerup_d;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    // Straps may change at any time, so each passes two flops first
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pin_meta_q <= PIN_RST;
            pin_sync_q <= PIN_RST;
        end else begin
            pin_meta_q <= {gain_select, cal_scale_select, rate_select_high, rate_select_low};
            pin_sync_q <= pin_meta_q;
        end
    end

    assign rate_sel_w = pin_sync_q[1:0];
    assign scale_w    = pin_sync_q[2];
    assign gain_w     = pin_sync_q[3];

    // ************************************************************
    // Internal oscillator tick
    // ************************************************************
    // Fractional divider; all rates scale with OSC_FREQ_HZ
    assign phase_sum_w = phase_q + TICK_W'(OSC_FREQ_HZ);
    assign osc_tick_w  = phase_sum_w >= TICK_W'(SYS_HZ);
    assign phase_d     = osc_tick_w ? phase_sum_w - TICK_W'(SYS_HZ) : phase_sum_w;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            phase_q <= '0;
        end else begin
            phase_q <= phase_d;
        end
    end

    // ************************************************************
    // Power path
    // ************************************************************
    // Billing input follows the fault state machine
    assign cur_sel_w  = state_q[1] ? neutral_current_input : phase_current_input;
    assign cur_gain_w = gain_w ? {cur_sel_w, 4'h0}
                               : {{GAIN_SHIFT{cur_sel_w[SAMPLE_W-1]}}, cur_sel_w};
    assign prod_w     = cur_gain_w * voltage_sample;

    // Low-pass keeps the dc term; the ac ripple is averaged by the accumulators
    assign lpf_d = lpf_q + {{LPF_SHIFT{prod_w[PROD_W-1]}}, prod_w} - (lpf_q >>> LPF_SHIFT);
    assign lpf_out_w = lpf_q[PROD_W+LPF_SHIFT-1:LPF_SHIFT];
    // Negative power is not billed; sinusoids average to half their peak product
    assign power_w = lpf_out_w[PROD_W-1] ? '0
                   : {{(ACC_W-PROD_W+1){1'b0}}, lpf_out_w[PROD_W-2:0]};

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            lpf_q <= '0;
        end else if (osc_tick_w) begin
            lpf_q <= lpf_d;
        end
    end

    // ************************************************************
    // Thresholds from the select pins
    // ************************************************************
    assign base_exp_w = BASE_EXP[rate_sel_w];
    assign cf_exp_w   = scale_w ? CF_EXP_HI[rate_sel_w] : CF_EXP_LO[rate_sel_w];
    // One low-rate quantum is ENERGY_Q oscillator-weighted base periods
    assign f_thr_w    = ACC_W'(ENERGY_Q) << base_exp_w;
    // Calibration quantum is the low-rate one divided by the ratio
    assign cf_thr_w   = f_thr_w >> cf_exp_w;

    // ************************************************************
    // Digital-to-frequency units
    // ************************************************************
    epfl_dfc_if #(.AW(ACC_W)) f_if ();
    epfl_dfc_if #(.AW(ACC_W)) cf_if ();

    assign f_if.tick       = osc_tick_w;
    assign f_if.power      = power_w;
    assign f_if.threshold  = f_thr_w;
    assign cf_if.tick      = osc_tick_w;
    assign cf_if.power     = power_w;
    assign cf_if.threshold = cf_thr_w;

    epfl_dfc #(
        .WIDTH_TICKS (F_PULSE_W),
        .CNT_W       (16)
    ) u_f_dfc (
        .sys_clk (sys_clk),
        .srst    (srst),
        .port    (f_if)
    );

    epfl_dfc #(
        .WIDTH_TICKS (CF_PULSE_TICKS),
        .CNT_W       (16)
    ) u_cf_dfc (
        .sys_clk (sys_clk),
        .srst    (srst),
        .port    (cf_if)
    );

    // Both low-rate outputs carry the same registered pulse
    assign energy_pulse_out_a    = f_if.pulse;
    assign energy_pulse_out_b    = f_if.pulse;
    assign calibration_pulse_out = cf_if.pulse;

    // ************************************************************
    // Current averaging for fault detection
    // ************************************************************
    assign cur_in_w[0] = phase_current_input;
    assign cur_in_w[1] = neutral_current_input;

    for (genvar i = 0; i < 2; i++) begin : g_avg
        logic [SAMPLE_W-1:0] neg_w;
        assign neg_w    = -cur_in_w[i];
        // Most negative code saturates instead of wrapping to zero
        assign mag_w[i] = !cur_in_w[i][SAMPLE_W-1] ? cur_in_w[i][MAG_W-1:0]
                        : neg_w[SAMPLE_W-1] ? '1 : neg_w[MAG_W-1:0];
        assign avg_w[i] = avg_q[i][MAG_W+CUR_AVG_SHIFT-1:CUR_AVG_SHIFT];

        always_ff @(posedge sys_clk) begin
            if (srst) begin
                avg_q[i] <= '0;
            end else if (osc_tick_w) begin
                avg_q[i] <= avg_q[i] + (MAG_W+CUR_AVG_SHIFT)'(mag_w[i])
                          - (avg_q[i] >> CUR_AVG_SHIFT);
            end
        end
    end

    // ************************************************************
    // Fault comparison
    // ************************************************************
    assign act_w   = state_q[1] ? avg_w[1] : avg_w[0];
    assign ina_w   = state_q[1] ? avg_w[0] : avg_w[1];
    // Light loads are noise; there the fault clears at once and the billing input is kept
    assign quiet_w = (avg_w[0] < NOISE_FLOOR) && (avg_w[1] < NOISE_FLOOR);
    // Difference measured against the larger of the two
    assign differ_w = (act_w >= ina_w) ? ((act_w - ina_w) > (act_w >> DIFF_SHIFT))
                                       : ((ina_w - act_w) > (ina_w >> DIFF_SHIFT));
    // Swap only when the idle input leads by 6.25 percent of itself
    assign swap_w   = (ina_w > act_w) && ((ina_w - act_w) > (ina_w >> DIFF_SHIFT));
    assign limit_w  = powerup_q ? FAULT_CNT_W'(FAULT_POWERUP_TICKS)
                                : FAULT_CNT_W'(FAULT_SETTLE_TICKS);

    // ************************************************************
    // Fault state machine
    // ************************************************************
    // Target state; an active input that still leads never swaps
    always_comb begin
        case (state_q)
            FS_NORM_PH, FS_FAULT_PH: begin
                want_w = swap_w ? FS_FAULT_NE : differ_w ? FS_FAULT_PH : FS_NORM_PH;
            end
            default: begin
                want_w = swap_w ? FS_FAULT_PH : differ_w ? FS_FAULT_NE : FS_NORM_NE;
            end
        endcase
    end

    // Outside quiet loads, change only after the target has held for the power-up time at first, then the settle time
    always_comb begin
        state_d   = state_q;
        fcnt_d    = '0;
        powerup_d = powerup_q;
        if (quiet_w) begin
            state_d = state_q[1] ? FS_NORM_NE : FS_NORM_PH;
        end else if (want_w != state_q) begin
            fcnt_d = fcnt_q + FAULT_CNT_W'(osc_tick_w);
            if (fcnt_d >= limit_w) begin
                state_d   = want_w;
                fcnt_d    = '0;
                powerup_d = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_q   <= FS_NORM_PH;
            fcnt_q    <= '0;
            powerup_q <= 1'b1;
        end else begin
            state_q   <= state_d;
            fcnt_q    <= fcnt_d;
            powerup_q <= powerup_d;
        end
    end

    // Flag taken straight from state, not from pulse activity
    assign fault_flag     = state_q[0];
    assign neutral_active = state_q[1];

endmodule

//--- shared/epfl_dfc_if.sv
// Link between the top level and one digital-to-frequency unit.
// Assumes all signals live on sys_clk.
`timescale 1ns/1ps
interface epfl_dfc_if #(
    parameter int unsigned AW = 52
);
    logic          tick;
    logic [AW-1:0] power;
    logic [AW-1:0] threshold;
    logic          pulse;

    modport src  (output tick, output power, output threshold, input pulse);
    modport unit (input tick, input power, input threshold, output pulse);
endinterface

//--- shared/epfl_pkg.sv
// Constants and types for the energy pulse and fault logic.
// Assumes a 100 MHz system clock and a 450 kHz oscillator tick made from it.
package epfl_pkg;

    // ************************************************************
    // Clocks and timing
    // ************************************************************
    localparam int unsigned SYS_HZ          = 100_000_000;
    localparam int unsigned OSC_HZ          = 450_000;
    localparam int unsigned MS_PER_S        = 1000;
    localparam int unsigned FAULT_POWERUP_MS = 1000;
    localparam int unsigned FAULT_SETTLE_MS  = 3000;
    localparam int unsigned F_PULSE_TICKS   = 32768;
    localparam int unsigned CF_PULSE_TICKS  = 18;
    localparam int unsigned TICK_W          = 32;
    localparam int unsigned FAULT_CNT_W     = 24;

    // ************************************************************
    // Datapath widths and filters
    // ************************************************************
    localparam int unsigned SAMPLE_W      = 16;
    localparam int unsigned MAG_W         = 15;
    localparam int unsigned GAIN_SHIFT    = 4;
    localparam int unsigned GAIN_W        = SAMPLE_W + GAIN_SHIFT;
    localparam int unsigned PROD_W        = GAIN_W + SAMPLE_W;
    localparam int unsigned LPF_SHIFT     = 14;
    localparam int unsigned CUR_AVG_SHIFT = 12;
    localparam int unsigned ACC_W         = 52;
    localparam int unsigned DIFF_SHIFT    = 4;

    // Full-scale dc product with unity gain gives 0.68 Hz at select 00
    localparam longint unsigned ENERGY_QUANTUM = 64'd2710588235;
    localparam logic [MAG_W-1:0] NOISE_FLOOR   = 15'h0062;

    // ************************************************************
    // Select tables, indexed by {rate_select_high, rate_select_low}
    // ************************************************************
    localparam logic [4:0] BASE_EXP   [4] = '{5'h12, 5'h11, 5'h10, 5'h0f};
    localparam logic [4:0] CF_EXP_HI  [4] = '{5'h07, 5'h06, 5'h05, 5'h04};
    localparam logic [4:0] CF_EXP_LO  [4] = '{5'h06, 5'h05, 5'h04, 5'h0b};

    // ************************************************************
    // Reset values and states
    // ************************************************************
    localparam logic [3:0] PIN_RST = 4'h0;

    typedef enum logic [1:0] {
        FS_NORM_PH  = 2'b00,
        FS_FAULT_PH = 2'b01,
        FS_FAULT_NE = 2'b11,
        FS_NORM_NE  = 2'b10
    } epfl_fault_state_t;

endpackage

//--- verif/epfl_energy_pulse_asserts.sv
// Concurrent checks on the energy pulse and fault logic.
// Sees only the top module ports; bound to it at the foot of the file.
`timescale 1ns/1ps
module epfl_energy_pulse_asserts
    import epfl_pkg::*;
#(
    parameter int unsigned F_PULSE_W           = 8,
    parameter int unsigned FAULT_POWERUP_TICKS = 20
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic energy_pulse_out_a,
    input wire logic energy_pulse_out_b,
    input wire logic calibration_pulse_out,
    input wire logic fault_flag,
    input wire logic neutral_active
);
    // ************************************************************
    // Helper counters
    // ************************************************************
    // Ticks come every 222 or 223 cycles, so bounds keep two cycles slack
    localparam int F_MIN   = F_PULSE_W * 222 - 2;
    localparam int CF_MIN  = CF_PULSE_TICKS * 222 - 2;
    // The settle count may start on a tick, so only limit-1 full intervals are certain
    localparam int FLT_MIN = (FAULT_POWERUP_TICKS - 1) * 222;
    logic [31:0] hi_a_q;
    logic [31:0] hi_cf_q;
    logic [31:0] calm_q;

    // High-run lengths and cycles since the fault outputs last moved
    always_ff @(posedge sys_clk) begin
        hi_a_q  <= (srst || !energy_pulse_out_a) ? 32'h0 : hi_a_q + 32'h1;
        hi_cf_q <= (srst || !calibration_pulse_out) ? 32'h0 : hi_cf_q + 32'h1;
        calm_q  <= (srst || $changed(fault_flag) || $changed(neutral_active)) ? 32'h0 : calm_q + 32'h1;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    // ************************************************************
    // Assertions and covers
    // ************************************************************
    AST_PAIR: assert property (energy_pulse_out_a == energy_pulse_out_b)
        else $error("low-rate outputs differ");
    AST_RST_QUIET: assert property (disable iff (1'b0) srst |=> !energy_pulse_out_a && !calibration_pulse_out
        && !fault_flag && !neutral_active)
        else $error("outputs active after reset edge");
    AST_WAKE_PHASE: assert property ($fell(srst) |-> !neutral_active && !fault_flag ##1 !energy_pulse_out_a)
        else $error("wake-up state not phase billing");
    AST_F_WIDTH: assert property ($fell(energy_pulse_out_a) |-> hi_a_q >= F_MIN)
        else $error("low-rate pulse too short");
    AST_CF_WIDTH: assert property ($fell(calibration_pulse_out) |-> hi_cf_q >= CF_MIN)
        else $error("calibration pulse too short");
    AST_FAULT_DELAY: assert property ($rose(fault_flag) |-> calm_q >= FLT_MIN)
        else $error("fault raised too early");
    AST_SWAP_DELAY: assert property ($changed(neutral_active) |-> calm_q >= FLT_MIN)
        else $error("billing input swapped too early");
    AST_SWAP_FAULT: assert property ($rose(neutral_active) |-> fault_flag)
        else $error("swap to neutral without fault");
    AST_SWAP_HOLD: assert property ($rose(neutral_active) |=> $stable(neutral_active) [*8])
        else $error("billing input chatters");
    CV_PULSE: cover property ($rose(energy_pulse_out_a));
    CV_CAL: cover property ($rose(calibration_pulse_out));
    CV_SWAP: cover property ($rose(neutral_active));
endmodule

bind epfl_energy_pulse epfl_energy_pulse_asserts #(
    .F_PULSE_W          (F_PULSE_W),
    .FAULT_POWERUP_TICKS(FAULT_POWERUP_TICKS)
) i_epfl_energy_pulse_asserts (
    .sys_clk              (sys_clk),
    .srst                 (srst),
    .energy_pulse_out_a   (energy_pulse_out_a),
    .energy_pulse_out_b   (energy_pulse_out_b),
    .calibration_pulse_out(calibration_pulse_out),
    .fault_flag           (fault_flag),
    .neutral_active       (neutral_active)
);

//--- verif/epfl_energy_pulse_tb.sv
// Self-checking bench for the energy pulse and fault logic.
// Assumes shortened counts; each case but the final neutral one starts from a fresh reset.
`timescale 1ns/1ps
module epfl_energy_pulse_tb;
    import epfl_pkg::*;
    localparam int unsigned     FW   = 1;
    localparam longint unsigned EQ   = 64'd336;
    localparam int unsigned     FLIM = 20;
    localparam int unsigned     SLIM = 60;
    logic               sys_clk;
    logic               srst;
    logic               clr;
    logic [3:0]         pins;
    logic signed [15:0] volt;
    logic signed [15:0] ph;
    logic signed [15:0] ne;
    logic               a;
    logic               b;
    logic               cf;
    logic               flt;
    logic               nact;
    logic [31:0]        n_a;
    logic [31:0]        n_b;
    logic [31:0]        n_cf;
    logic [31:0]        w_a;
    logic [31:0]        c00;
    logic [31:0]        c1;
    logic [31:0]        c11;
    int                 fail_count;
    int                 n_tests;

    epfl_energy_pulse #(
        .ENERGY_Q           (EQ),
        .F_PULSE_W          (FW),
        .FAULT_POWERUP_TICKS(FLIM),
        .FAULT_SETTLE_TICKS (SLIM)
    ) i_epfl_energy_pulse (
        .sys_clk              (sys_clk),
        .srst                 (srst),
        .voltage_sample       (volt),
        .phase_current_input  (ph),
        .neutral_current_input(ne),
        .rate_select_high     (pins[3]),
        .rate_select_low      (pins[2]),
        .cal_scale_select     (pins[1]),
        .gain_select          (pins[0]),
        .energy_pulse_out_a   (a),
        .energy_pulse_out_b   (b),
        .calibration_pulse_out(cf),
        .fault_flag           (flt),
        .neutral_active       (nact)
    );
    epfl_pulse_counter i_cnt_a (.sys_clk(sys_clk), .clr(clr), .pulse(a), .rises(n_a), .last_width(w_a));
    epfl_pulse_counter i_cnt_b (.sys_clk(sys_clk), .clr(clr), .pulse(b), .rises(n_b), .last_width());
    epfl_pulse_counter i_cnt_cf (.sys_clk(sys_clk), .clr(clr), .pulse(cf), .rises(n_cf), .last_width());

    // ************************************************************
    // Clock, tasks and watchdog
    // ************************************************************
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic check_rng(input string what, input logic [31:0] lo, input logic [31:0] hi,
                             input logic [31:0] seen);
        n_tests++;
        if ((seen >= lo && seen <= hi) !== 1'b1) begin
            fail_count++;
            $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, seen);
        end
    endtask

    // Pins and samples are applied during reset, then held for the window
    task automatic run(input logic [3:0] p, input logic signed [15:0] v, input logic signed [15:0] ip,
                       input logic signed [15:0] in, input int ticks);
        @(posedge sys_clk);
        pins <= p;
        volt <= v;
        ph   <= ip;
        ne   <= in;
        srst <= 1'b1;
        clr  <= 1'b1;
        repeat (4) @(posedge sys_clk);
        srst <= 1'b0;
        clr  <= 1'b0;
        repeat (ticks * 2223 / 10) @(posedge sys_clk);
    endtask

    task automatic results();
        $display("tests %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Whole sequence needs about 106k cycles
    initial begin
        repeat (130000) @(posedge sys_clk);
        fail_count++;
        results();
    end

    // ************************************************************
    // Scenarios
    // ************************************************************
    // Pins are {rate high, rate low, cal scale, gain}
    initial begin
        srst = 1'b1;
        clr = 1'b1;
        pins = 4'h0;
        volt = 16'sh0000;
        ph = 16'sh0000;
        ne = 16'sh0000;
        fail_count = 0;
        n_tests = 0;
        // Same power, base 2^18 then 2^15: floor of energy gives 8x the count
        run(4'b0010, 16'sd32000, 16'sd32000, 16'sd32000, 65);
        c00 = n_a;
        run(4'b1100, 16'sd32000, 16'sd32000, 16'sd32000, 65);
        c11 = n_a;
        check_rng("rate ratio", 8 * c00, 8 * c00 + 7, n_a);
        check_rng("rate count", 1, 40, n_a);
        check_rng("low-rate width", 222 * FW - 1, 223 * FW + 1, w_a);
        check_rng("paired output count", n_a, n_a, n_b);
        // Calibration threshold F>>6 with scale high, F>>4 at half the base with scale low
        run(4'b0110, 16'sd256, 16'sd32000, 16'sd32000, 65);
        c1 = n_cf;
        run(4'b1000, 16'sd256, 16'sd32000, 16'sd32000, 65);
        check_rng("cal ratio", 2 * n_cf, 2 * n_cf + 1, c1);
        // Gain 16 on a 16x smaller current gives the power of the second run
        run(4'b1101, 16'sd32000, 16'sd2000, 16'sd2000, 65);
        check_rng("gain scaling", c11, c11, n_a);
        // Reversed power, neutral missing: fault on phase, no pulses
        run(4'b0000, -16'sd32000, 16'sd32000, 16'sh0000, 40);
        check_rng("reversed power pulses", 0, 0, n_a);
        check_rng("fault with phase larger", 1, 1, {31'h0, flt});
        check_rng("billing stays on phase", 0, 0, {31'h0, nact});
        // Neutral just under the noise floor, held well past the fault limit
        run(4'b0000, 16'sh0000, 16'sh0000, 16'sd97, 70);
        check_rng("quiet fault flag", 0, 0, {31'h0, flt});
        // Neutral at full scale: fault and swap
        ne <= 16'sd32000;
        repeat (40 * 2223 / 10) @(posedge sys_clk);
        check_rng("fault with neutral larger", 1, 1, {31'h0, flt});
        check_rng("billing on neutral", 1, 1, {31'h0, nact});
        results();
    end
endmodule

//--- verif/epfl_pulse_counter.sv
// Model of the pulse counter that sits on one pulse output.
// Assumes the pulse is a registered level on sys_clk.
`timescale 1ns/1ps
module epfl_pulse_counter (
    input wire logic  sys_clk,
    input wire logic  clr,
    input wire logic  pulse,
    output logic [31:0] rises,
    output logic [31:0] last_width
);
    logic [31:0] run_q  = 32'h0;
    logic        prev_q = 1'b0;

    // Counts rising edges; width kept only for pulses that ended
    always @(posedge sys_clk) begin
        if (clr) begin
            rises      <= 32'h0;
            last_width <= 32'h0;
        end else if (pulse && !prev_q) begin
            rises <= rises + 32'h1;
        end else if (!pulse && prev_q) begin
            last_width <= run_q;
        end
        run_q  <= pulse ? run_q + 32'h1 : 32'h0;
        prev_q <= pulse;
    end
endmodule
